/* File: design/mpdg_pkg.sv */
// Package for the micro port decode glue: widths, counts, carriers.
// Assumes a single 100 MHz system clock and synchronous pin inputs.
package mpdg_pkg;
    localparam int DATA_W       = 8;     // Port and FIFO byte width
    localparam int ADDR_W       = 4;     // Port address lines
    localparam int NUM_PORTS    = 16;    // Decoded port addresses 0..15
    localparam int NUM_LOAD     = 5;     // Load/input strobes, ports 0..4
    localparam int LAST_LOAD    = 4;     // Highest load/input port
    localparam int TESTPT_PORT  = 9;     // Decoder output used as test point
    localparam int MUX_SEL_W    = 3;     // Request mux select width
    localparam int ROM_HALF_WDS = 512;   // Words per program ROM half
    localparam int ROM_WORDS    = 1024;  // Combined program store
    localparam int INSN_W       = 12;    // Instruction width
    localparam int ROM_AW       = 10;    // Program address width
    localparam int FIFO_DEPTH   = 16;    // Output FIFO depth in bytes
    localparam logic REQ_IDLE   = 1'b0;  // Request line inactive level

    // Processor I/O control outputs, one sample per cycle
    typedef struct packed {
        logic io_control_flag;
        logic io_exchange_n;
        logic direction;
    } mpdg_ctl_t;

    // Decoded transfer direction lines
    typedef struct packed {
        logic write_hi;      // High-active write
        logic write_n;       // Low-active write
        logic write_1;       // High-active transceiver direction
        logic fifo_dump_n;   // Low-active FIFO dump
    } mpdg_dir_t;
endpackage

/* File: design/mpdg_fifo.sv */
// Output FIFO holding bytes for the processor, width and depth set by
// parameters. Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module mpdg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_i,
    input  wire logic             arst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // Pointers, fill count and both flags form one registered state
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
        logic          ready;
        logic          valid;
    } mpdg_fifo_st_t;

    mpdg_fifo_st_t    s_q;
    mpdg_fifo_st_t    s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // Flags are registered so the fill-side ready leaves from a flop
    assign in_ready_o  = s_q.ready;
    assign out_valid_o = s_q.valid;
    assign out_data_o  = mem[s_q.rd];
    assign push        = in_valid_i && s_q.ready;
    assign pop         = s_q.valid && out_ready_i;

    // Storage has no reset; only written slots are ever read
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[s_q.wr] <= in_data_i;
        end
    end

    // Next pointers and count; flags look ahead at the next count
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        // Full refuses writes so the source really stalls
        s_d.ready = (s_d.cnt != (AW+1)'(DEPTH));
        s_d.valid = (s_d.cnt != '0);
    end

    // State register; empty and ready after reset
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '{ready: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

/* File: design/mpdg_top.sv */
// Glue between the controller core and its ports: I/O control decode,
// port strobes, request mux, FIFO dump path and ROM bank select.
// Assumes all pin inputs are synchronous to clk_sys_i; the phase-one
// clock arrives as a sampled level and is used as a strobe qualifier.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Two 512x12 ROM halves; bank select level picks which one drives.
// [R2] Combined store holds 1024 instructions of 12 bits.
// [R3] Four address lines decode into sixteen port addresses 0..15.
// [R4] Address lines weigh 1, 2, 4, 8; address 9 is lines 0 and 3.
// [R5] Control inputs decode to read or write direction pattern.
// [R6] Read with dump asserted presents next FIFO byte to processor.
// [R7] Processor data goes inverted to port bus only during write.
// [R8] All ports share the bus; only the addressed port latches.
// [R9] Addresses 0..4 strobe ports; 8..15 route status to request line.
// [R10] Decoder strobes only ports 0..4; port 9 output is test point.
// [R11] Mux enabled for addresses 8..15, selecting by lower three lines.
// [R12] Processor waits for request feedback after loading a command.
// [R13] Processor checks platen closed before loading printer port 4.
// [R14] Processor polls forms timing unit status at address 9.
// [R15] Port strobe is write AND decoded address AND phase-one pulse.
// [R16] Request output idles inactive while address bit 3 is clear.
module mpdg_top
    import mpdg_pkg::*;
#(
    parameter int FIFO_W = mpdg_pkg::DATA_W,
    parameter int FIFO_D = mpdg_pkg::FIFO_DEPTH
) (
    input  wire logic                           clk_sys_i,
    input  wire logic                           arst_n_i,
    input  wire mpdg_pkg::mpdg_ctl_t            ctl_i,
    input  wire logic [mpdg_pkg::ADDR_W-1:0]    port_addr_i,
    input  wire logic                           phase_one_i,
    input  wire logic [mpdg_pkg::DATA_W-1:0]    cpu_data_bus_n_i,
    output logic      [mpdg_pkg::DATA_W-1:0]    cpu_data_bus_n_o,
    output logic                                cpu_data_bus_n_oe_o,
    output logic      [mpdg_pkg::DATA_W-1:0]    port_data_bus_o,
    output logic      [mpdg_pkg::NUM_LOAD-1:0]  port_strobe_o,
    output logic                                decode_nine_testpoint_o,
    input  wire logic [2**mpdg_pkg::MUX_SEL_W-1:0] status_i,
    output logic                                request_feedback_o,
    output mpdg_pkg::mpdg_dir_t                 dir_o,
    input  wire logic                           rom_bank_select_i,
    input  wire logic [mpdg_pkg::ROM_AW-2:0]    rom_addr_i,
    input  wire logic [mpdg_pkg::INSN_W-1:0]    rom_lo_data_i,
    input  wire logic [mpdg_pkg::INSN_W-1:0]    rom_hi_data_i,
    output logic      [mpdg_pkg::INSN_W-1:0]    insn_o,
    output logic      [mpdg_pkg::ROM_AW-1:0]    insn_addr_o,
    input  wire logic                           fifo_in_valid_i,
    output logic                                fifo_in_ready_o,
    input  wire logic [mpdg_pkg::DATA_W-1:0]    fifo_in_data_i
);
    import mpdg_pkg::*;

    // Whole module state, registered once per cycle
    typedef struct packed {
        logic [DATA_W-1:0]    cpu_out;
        logic                 cpu_oe;
        logic [DATA_W-1:0]    port_bus;
        logic [NUM_LOAD-1:0]  strobe;
        logic                 tp9;
        logic                 req;
        mpdg_dir_t            dir;
        logic [INSN_W-1:0]    insn;
        logic [ROM_AW-1:0]    iaddr;
        logic                 dump_prev;
    } mpdg_state_t;

    mpdg_state_t       s_q;
    mpdg_state_t       s_d;
    logic              is_read;
    logic              is_write;
    logic              fifo_valid;
    logic              fifo_pop;
    logic [DATA_W-1:0] fifo_data;
    logic [NUM_PORTS-1:0] dec;

    // One-hot decode of the binary-weighted address lines
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_dec
            assign dec[gi] = (port_addr_i == ADDR_W'(gi)); // see [R3] [R4]
        end
    endgenerate

    // Read and write patterns are only legal with flag and exchange low
    assign is_read  = !ctl_i.io_control_flag && !ctl_i.io_exchange_n
                      && !ctl_i.direction;                  // see [R5]
    assign is_write = !ctl_i.io_control_flag && !ctl_i.io_exchange_n
                      && ctl_i.direction;                   // see [R5]

    // A byte leaves the FIFO once per dump assertion, on its leading edge,
    // so a long read cannot drain several bytes at once
    assign fifo_pop = is_read && !s_q.dump_prev && fifo_valid; // see [R6]

    mpdg_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (fifo_in_valid_i),
        .in_ready_o  (fifo_in_ready_o),
        .in_data_i   (fifo_in_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_data)
    );

    // Next-state logic for every output
    always_comb begin
        s_d = s_q;
        s_d.dump_prev = is_read;
        // Neither pattern: transceivers idle, both directions released
        s_d.dir.write_hi    = is_write;                      // see [R5]
        s_d.dir.write_n     = !is_write;                     // see [R5]
        s_d.dir.write_1     = is_write;                      // see [R5]
        s_d.dir.fifo_dump_n = !is_read;                      // see [R5]
        // Read returns the FIFO byte inverted onto the low-true pins
        s_d.cpu_oe = is_read;                                // see [R6]
        if (fifo_pop) begin
            s_d.cpu_out = ~fifo_data;                        // see [R6]
        end
        // Port bus follows processor data only during a write
        if (is_write) begin
            s_d.port_bus = ~cpu_data_bus_n_i;                // see [R7]
        end
        // Only the addressed port 0..4 gets a strobe
        for (int i = 0; i < NUM_LOAD; i++) begin
            s_d.strobe[i] = is_write && dec[i]
                            && phase_one_i;           // see [R8] [R10] [R15]
        end
        s_d.tp9 = dec[TESTPT_PORT];                          // see [R10]
        // Mux enabled by the top line; lower lines pick the status input
        if (port_addr_i[ADDR_W-1]) begin
            s_d.req = status_i[port_addr_i[MUX_SEL_W-1:0]];  // see [R9] [R11]
        end else begin
            s_d.req = REQ_IDLE;                              // see [R16]
        end
        // Bank select level chooses which ROM half drives the bus
        s_d.insn  = rom_bank_select_i ? rom_hi_data_i
                                      : rom_lo_data_i;       // see [R1]
        s_d.iaddr = {rom_bank_select_i, rom_addr_i};         // see [R2]
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '{dir: '{write_hi: 1'b0, write_n: 1'b1, write_1: 1'b0,
                            fifo_dump_n: 1'b1}, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign cpu_data_bus_n_o        = s_q.cpu_out;
    assign cpu_data_bus_n_oe_o     = s_q.cpu_oe;
    assign port_data_bus_o         = s_q.port_bus;
    assign port_strobe_o           = s_q.strobe;
    assign decode_nine_testpoint_o = s_q.tp9;
    assign request_feedback_o      = s_q.req;
    assign dir_o                   = s_q.dir;
    assign insn_o                  = s_q.insn;
    assign insn_addr_o             = s_q.iaddr;

    // Checks on the glue outputs; one clock domain, reset disables all
    default clocking cb_chk @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence seq_write_strobe;
        is_write && phase_one_i;
    endsequence

    AST_ROM_BANK: assert property ( // see [R1]
        1'b1 |=> insn_o == ($past(rom_bank_select_i) ? $past(rom_hi_data_i)
                 : $past(rom_lo_data_i)))
        else $error("ROM half does not follow bank select");
    AST_ROM_ADDR: assert property ( // see [R2]
        1'b1 |=> insn_addr_o[ROM_AW-1] == $past(rom_bank_select_i))
        else $error("Program address top bit wrong");
    AST_DIR_READ: assert property ( // see [R5]
        is_read |=> !dir_o.write_hi && dir_o.write_n && !dir_o.write_1
                    && !dir_o.fifo_dump_n)
        else $error("Read direction pattern wrong");
    AST_DIR_WRITE: assert property ( // see [R5]
        is_write |=> dir_o.write_hi && !dir_o.write_n && dir_o.write_1
                     && dir_o.fifo_dump_n)
        else $error("Write direction pattern wrong");
    AST_DUMP: assert property ( // see [R6]
        fifo_pop |=> cpu_data_bus_n_oe_o
                     && cpu_data_bus_n_o == ~$past(fifo_data))
        else $error("Dumped byte not on processor pins");
    AST_DUMP_HOLD: assert property ( // see [R6]
        !fifo_pop |=> $stable(cpu_data_bus_n_o))
        else $error("Processor byte changed without a dump");
    AST_READ_OE: assert property ( // see [R6]
        !is_read |=> !cpu_data_bus_n_oe_o)
        else $error("Processor pins driven outside a read");
    AST_PORT_BUS: assert property ( // see [R7]
        !is_write |=> $stable(port_data_bus_o))
        else $error("Port bus changed outside a write");
    AST_PORT_WRITE: assert property ( // see [R7]
        is_write |=> port_data_bus_o == ~$past(cpu_data_bus_n_i))
        else $error("Port bus does not carry inverted processor data");
    AST_STROBE: assert property ( // see [R8] [R15]
        seq_write_strobe and (port_addr_i <= ADDR_W'(LAST_LOAD))
        |=> $onehot(port_strobe_o))
        else $error("Addressed port did not strobe alone");
    AST_STROBE_SEL: assert property ( // see [R8]
        seq_write_strobe ##0 (port_addr_i <= ADDR_W'(LAST_LOAD))
        |=> port_strobe_o == (NUM_LOAD'(1) << $past(port_addr_i)))
        else $error("Strobe went to a port other than the addressed one");
    AST_NO_STROBE: assert property ( // see [R9] [R10]
        (port_addr_i > ADDR_W'(LAST_LOAD)) || !is_write
        |=> port_strobe_o == '0)
        else $error("Strobe outside ports 0 to 4");
    AST_TESTPT: assert property ( // see [R10]
        1'b1 |=> decode_nine_testpoint_o
                 == ($past(port_addr_i) == ADDR_W'(TESTPT_PORT)))
        else $error("Test point does not follow address 9");
    AST_REQ_MUX: assert property ( // see [R11]
        port_addr_i[ADDR_W-1] |=> request_feedback_o
            == $past(status_i[port_addr_i[MUX_SEL_W-1:0]]))
        else $error("Request mux selects wrong input");
    AST_REQ_IDLE: assert property ( // see [R16]
        !port_addr_i[ADDR_W-1] |=> request_feedback_o == REQ_IDLE)
        else $error("Request line active while disabled");
endmodule
`default_nettype wire

/* File: tb/mpdg_rom_model.sv */
// Program store model: two 512x12 halves beside the controller core.
// Assumes the glue picks one half by bank select and registers it.
`timescale 1ns/1ps
`default_nettype none
module mpdg_rom_model (
    input  wire logic [8:0]  rom_addr_i,
    output logic      [11:0] lo_data_o,
    output logic      [11:0] hi_data_o
);
    // Distinct top bits per half so a wrong pick shows at once
    assign lo_data_o = {3'h2, rom_addr_i};
    assign hi_data_o = {3'h5, rom_addr_i};
endmodule
`default_nettype wire

/* File: tb/micro_port_decode_glue_test.sv */
// Self-checking bench for the port decode glue and its output FIFO.
// Assumes registered outputs one cycle after the sampling edge.
`timescale 1ns/1ps
`default_nettype none
module micro_port_decode_glue_test;
    import mpdg_pkg::*;
    localparam mpdg_ctl_t RD = 3'h0, WR = 3'h1, IDLE = 3'h6;
    logic        clk_sys_i = 1'b0, arst_n_i = 1'b0, ph1 = 1'b0;
    mpdg_ctl_t   ctl = IDLE;
    mpdg_dir_t   dir;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  dn_in = 8'h00, dn_out, pbus, status = 8'h00, fd = 8'h00;
    logic [4:0]  strb;
    logic        oe, tp, req, bank = 1'b0, fv = 1'b0, fr;
    logic [8:0]  raddr = 9'h000;
    logic [11:0] lo, hi, insn;
    logic [9:0]  iaddr;
    int          bad_count = 0, checks_done = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    mpdg_rom_model rom (.rom_addr_i(raddr), .lo_data_o(lo), .hi_data_o(hi));
    mpdg_top uut (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ctl_i(ctl),
        .port_addr_i(addr), .phase_one_i(ph1), .cpu_data_bus_n_i(dn_in),
        .cpu_data_bus_n_o(dn_out), .cpu_data_bus_n_oe_o(oe),
        .port_data_bus_o(pbus), .port_strobe_o(strb),
        .decode_nine_testpoint_o(tp), .status_i(status),
        .request_feedback_o(req), .dir_o(dir), .rom_bank_select_i(bank),
        .rom_addr_i(raddr), .rom_lo_data_i(lo), .rom_hi_data_i(hi),
        .insn_o(insn), .insn_addr_o(iaddr), .fifo_in_valid_i(fv),
        .fifo_in_ready_o(fr), .fifo_in_data_i(fd));

    // One compare; counts every call, reports only mismatches
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic t_reset();
        chk("dir", 16'(dir), 16'h5);
        chk("oe", 16'(oe), 16'h0);
        chk("strobe", 16'(strb), 16'h0);
        chk("req", 16'(req), 16'h0);
        chk("ready", 16'(fr), 16'h1);
    endtask

    // Every address written; only ports 0..4 may strobe
    task automatic t_write();
        logic [7:0] d;
        logic [4:0] e;
        for (int a = 0; a < 16; a++) begin
            d = {4'(a), ~4'(a)};
            e = (a <= 4) ? (5'h01 << a) : 5'h00;
            @(negedge clk_sys_i);
            ctl = WR;
            addr = 4'(a);
            ph1 = 1'b1;
            dn_in = ~d;
            @(negedge clk_sys_i);
            chk("pbus", 16'(pbus), 16'(d));
            chk("strobe", 16'(strb), 16'(e));
            chk("tp", 16'(tp), 16'(a == 9));
            chk("dir", 16'(dir), 16'hB);
        end
        // No phase-one pulse means no latch strobe
        addr = 4'h2;
        ph1 = 1'b0;
        @(negedge clk_sys_i);
        chk("strobe", 16'(strb), 16'h0);
        // Refused pattern: bus keeps the last written byte, 8'hF0
        ctl = IDLE;
        dn_in = 8'h00;
        @(negedge clk_sys_i);
        chk("pbus", 16'(pbus), 16'hF0);
        chk("dir", 16'(dir), 16'h5);
    endtask

    // Status polling over all sixteen addresses, two patterns
    task automatic t_req();
        logic [7:0] s;
        logic       e;
        for (int k = 0; k < 2; k++) begin
            s = k ? 8'h5A : 8'hA5;
            for (int a = 0; a < 16; a++) begin
                @(negedge clk_sys_i);
                status = s;
                addr = 4'(a);
                @(negedge clk_sys_i);
                e = a[3] ? s[a[2:0]] : 1'b0;
                chk("req", 16'(req), 16'(e));
            end
        end
    endtask

    // Fill until refused, one byte per read until empty, then one read more on the empty FIFO
    task automatic t_fifo();
        logic [7:0] b;
        for (int i = 0; i < 16; i++) begin
            @(negedge clk_sys_i);
            chk("ready", 16'(fr), 16'h1);
            fv = 1'b1;
            fd = 8'h30 + 8'(i);
        end
        @(negedge clk_sys_i);
        chk("ready", 16'(fr), 16'h0);
        fv = 1'b0;
        for (int i = 0; i < 17; i++) begin
            b = ~(8'h30 + 8'(i < 16 ? i : 15));
            @(negedge clk_sys_i);
            ctl = RD;
            @(negedge clk_sys_i);
            chk("dump", 16'(dn_out), 16'(b));
            chk("oe", 16'(oe), 16'h1);
            chk("dir", 16'(dir), 16'h4);
            @(negedge clk_sys_i);
            chk("hold", 16'(dn_out), 16'(b));
            ctl = IDLE;
            @(negedge clk_sys_i);
            chk("oe", 16'(oe), 16'h0);
        end
        chk("ready", 16'(fr), 16'h1);
    endtask

    // One port load as the processor does it; strobe and shared bus
    task automatic wr_port(input logic [3:0] pa, input logic [7:0] d,
                           input logic [4:0] e);
        @(negedge clk_sys_i);
        ctl = WR;
        addr = pa;
        ph1 = 1'b1;
        dn_in = ~d;
        @(negedge clk_sys_i);
        chk("load", 16'(strb), 16'(e));
        chk("lbus", 16'(pbus), 16'(d));
        ctl = IDLE;
        ph1 = 1'b0;
    endtask

    // Processor flow: platen check before port 4, timing poll, then wait
    task automatic t_proc();
        int n;
        @(negedge clk_sys_i);
        status = 8'h00;
        addr = 4'h8;
        @(negedge clk_sys_i);
        chk("platen", 16'(req), 16'h0);
        // Carriage is closed first, then the printer port is loaded
        status = 8'h01;
        @(negedge clk_sys_i);
        chk("platen", 16'(req), 16'h1);
        wr_port(4'h4, 8'h5C, 5'h10);
        // Forms load is timed by the timing unit seen at address 9
        addr = 4'h9;
        status = 8'h02;
        @(negedge clk_sys_i);
        chk("timing", 16'(req), 16'h1);
        wr_port(4'h1, 8'hA3, 5'h02);
        // After the load the processor waits for completion feedback
        addr = 4'h9;
        status = 8'h00;
        @(negedge clk_sys_i);
        chk("busy", 16'(req), 16'h0);
        status = 8'h02;
        n = 0;
        while (req !== 1'b1 && n < 4) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk("done", 16'(n), 16'h1);
    endtask

    task automatic t_rom();
        logic [8:0]  a;
        logic [11:0] w;
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 3; k++) begin
                a = (k == 0) ? 9'h000 : ((k == 1) ? 9'h1FF : 9'h0AA);
                @(negedge clk_sys_i);
                bank = 1'(b);
                raddr = a;
                @(negedge clk_sys_i);
                w = {b ? 3'h5 : 3'h2, a};
                chk("insn", 16'(insn), 16'(w));
                chk("iaddr", 16'(iaddr), 16'({1'(b), a}));
            end
        end
    endtask

    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (3) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        t_reset();
        t_write();
        t_req();
        t_fifo();
        t_proc();
        t_rom();
        wrap_up();
    end
endmodule
`default_nettype wire
